/* File: src/port_pkg.sv */
package port_pkg;

  // ****************************************************************
  // Register offsets on the internal processor bus.
  // ****************************************************************
  localparam logic [7:0] port_a_data_offset = 8'h00;
  localparam logic [7:0] port_b_data_offset = 8'h01;
  localparam logic [7:0] port_c_data_offset = 8'h02;
  localparam logic [7:0] port_d_data_offset = 8'h03;
  localparam logic [7:0] port_a_dir_offset = 8'h04;
  localparam logic [7:0] port_b_dir_offset = 8'h05;
  localparam logic [7:0] port_c_dir_offset = 8'h06;
  localparam logic [7:0] nv_clock_ctrl_offset = 8'h07;
  localparam logic [7:0] converter_ctrl_offset = 8'h09;

  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int clock_out_select_bit = 3;
  localparam int nv_erase_select_bit = 2;
  localparam int nv_latch_select_bit = 1;
  localparam int nv_program_pulse_bit = 0;
  localparam int converter_power_on_bit = 5;
  localparam int clock_out_pin = 2;
  localparam logic [7:0] dir_reset_value = 8'h00;
  localparam logic [3:0] nv_clock_ctrl_reset_value = 4'h0;
  localparam logic converter_power_on_reset_value = 1'b0;

endpackage

/* File: src/pin_sync.sv */
`timescale 1ns/100ps

// Two-flop synchroniser for a group of pin levels.
module pin_sync (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [7:0] async_in,
  output logic [7:0] sync_out
);

  logic [7:0] stage1_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage1_q <= 8'h00;
      sync_out <= 8'h00;
    end else begin
      stage1_q <= async_in;
      sync_out <= stage1_q;
    end
  end

endmodule

/* File: src/parallel_io_ports.sv */
`timescale 1ns/100ps

// What this block does
// - Three 8-bit bidirectional ports and one 8-bit input-only port.
// - A bidirectional pin drives when its direction bit is one.
// - Reset clears every direction register, making all pins inputs.
// - Direction registers are readable and writable by the processor.
// - Data writes always update the latch; drive only when output.
// - Data reads return latch for outputs, live pin for inputs.
// - Reset leaves the output latches unchanged.
// - Clock select routes a clock at half the core rate onto port C pin 2.
// - Clock select forces pin 2 direction to one; reads return latch.
// - Clock select clears on reset and holds until the register is written.
// - Input-only port has no direction register; feeds the converter.
// - After reset the converter is off; port reads as digital.
// - Converter power bit drives converter_power_on_out; port reads stay digital; reset clears.
module parallel_io_ports (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // Processor register bus.
  input wire logic [7:0] bus_addr_in,
  input wire logic bus_write_in,
  input wire logic bus_read_in,
  input wire logic [7:0] bus_wdata_in,
  output logic [7:0] bus_rdata_out,
  // Bidirectional port pins.
  input wire logic [7:0] port_a_pins_in,
  output logic [7:0] port_a_pins_out,
  output logic [7:0] port_a_pins_oe_out,
  input wire logic [7:0] port_b_pins_in,
  output logic [7:0] port_b_pins_out,
  output logic [7:0] port_b_pins_oe_out,
  input wire logic [7:0] port_c_pins_in,
  output logic [7:0] port_c_pins_out,
  output logic [7:0] port_c_pins_oe_out,
  // Input-only port and converter hand-off.
  input wire logic [7:0] shared_input_pins_in,
  output logic converter_power_on_out,
  output logic [2:0] nv_ctrl_out
);

  // ****************************************************************
  // Storage.
  // ****************************************************************
  logic [7:0] latch_a_q;
  logic [7:0] latch_b_q;
  logic [7:0] latch_c_q;
  logic [7:0] dir_a_q;
  logic [7:0] dir_b_q;
  logic [7:0] dir_c_q;
  logic clock_out_select_q;
  logic [2:0] nv_bits_q;
  logic converter_power_on_q;
  logic clk_div_q;
  logic [7:0] sync_a;
  logic [7:0] sync_b;
  logic [7:0] sync_c;
  logic [7:0] sync_d;
  logic [7:0] dir_c_eff;
  logic [7:0] drive_c;
  logic [7:0] rdata_d;

  // Merges latch and pin per bit according to direction.
  function automatic logic [7:0] port_view(input logic [7:0] dir,
                                           input logic [7:0] latch,
                                           input logic [7:0] pins);
    port_view = (dir & latch) | (~dir & pins);
  endfunction

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  // synchronise pin levels
  pin_sync sync_a_inst (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(port_a_pins_in),
    .sync_out(sync_a)
  );
  pin_sync sync_b_inst (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(port_b_pins_in),
    .sync_out(sync_b)
  );
  pin_sync sync_c_inst (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(port_c_pins_in),
    .sync_out(sync_c)
  );
  pin_sync sync_d_inst (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(shared_input_pins_in),
    .sync_out(sync_d)
  );

  // ****************************************************************
  // Output latches.
  // ****************************************************************
  // latches ignore reset
  always_ff @(posedge core_clk_in) begin
    if (bus_write_in && bus_addr_in == port_pkg::port_a_data_offset) begin
      latch_a_q <= bus_wdata_in;
    end
    if (bus_write_in && bus_addr_in == port_pkg::port_b_data_offset) begin
      latch_b_q <= bus_wdata_in;
    end
    if (bus_write_in && bus_addr_in == port_pkg::port_c_data_offset) begin
      latch_c_q <= bus_wdata_in;
    end
  end

  // ****************************************************************
  // Direction registers.
  // ****************************************************************
  // reset clears directions
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dir_a_q <= port_pkg::dir_reset_value;
      dir_b_q <= port_pkg::dir_reset_value;
      dir_c_q <= port_pkg::dir_reset_value;
    end else if (bus_write_in) begin
      if (bus_addr_in == port_pkg::port_a_dir_offset) begin
        dir_a_q <= bus_wdata_in;
      end else if (bus_addr_in == port_pkg::port_b_dir_offset) begin
        dir_b_q <= bus_wdata_in;
      end else if (bus_addr_in == port_pkg::port_c_dir_offset) begin
        dir_c_q <= bus_wdata_in;
      end
    end
  end

  // ****************************************************************
  // Clock-out and non-volatile control register.
  // ****************************************************************
  // cleared by reset or by a write of zero
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      clock_out_select_q <=
        port_pkg::nv_clock_ctrl_reset_value[port_pkg::clock_out_select_bit];
      nv_bits_q <= {
        port_pkg::nv_clock_ctrl_reset_value[port_pkg::nv_erase_select_bit],
        port_pkg::nv_clock_ctrl_reset_value[port_pkg::nv_latch_select_bit],
        port_pkg::nv_clock_ctrl_reset_value[port_pkg::nv_program_pulse_bit]
      };
    end else if (bus_write_in &&
                 bus_addr_in == port_pkg::nv_clock_ctrl_offset) begin
      clock_out_select_q <= bus_wdata_in[port_pkg::clock_out_select_bit];
      nv_bits_q <= {bus_wdata_in[port_pkg::nv_erase_select_bit],
                    bus_wdata_in[port_pkg::nv_latch_select_bit],
                    bus_wdata_in[port_pkg::nv_program_pulse_bit]};
    end
  end

  // ****************************************************************
  // Converter power bit.
  // ****************************************************************
  // converter power drives the output only
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      converter_power_on_q <= port_pkg::converter_power_on_reset_value;
    end else if (bus_write_in &&
                 bus_addr_in == port_pkg::converter_ctrl_offset) begin
      converter_power_on_q <= bus_wdata_in[port_pkg::converter_power_on_bit];
    end
  end

  // ****************************************************************
  // Clock output source, a flop at half the core rate.
  // ****************************************************************
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      clk_div_q <= 1'b0;
    end else begin
      clk_div_q <= ~clk_div_q;
    end
  end

  // ****************************************************************
  // Effective port C direction and drive values.
  // ****************************************************************
  // force pin 2 direction
  always_comb begin
    dir_c_eff = dir_c_q;
    drive_c = latch_c_q;
    if (clock_out_select_q) begin
      dir_c_eff[port_pkg::clock_out_pin] = 1'b1;
      drive_c[port_pkg::clock_out_pin] = ~clk_div_q;
    end
  end

  // ****************************************************************
  // Pin drivers, registered.
  // ****************************************************************
  // drive when direction is one
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      port_a_pins_out <= 8'h00;
      port_b_pins_out <= 8'h00;
      port_c_pins_out <= 8'h00;
      port_a_pins_oe_out <= 8'h00;
      port_b_pins_oe_out <= 8'h00;
      port_c_pins_oe_out <= 8'h00;
    end else begin
      port_a_pins_out <= latch_a_q;
      port_b_pins_out <= latch_b_q;
      port_c_pins_out <= drive_c;
      port_a_pins_oe_out <= dir_a_q;
      port_b_pins_oe_out <= dir_b_q;
      port_c_pins_oe_out <= dir_c_eff;
    end
  end

  // ****************************************************************
  // Read multiplexer.
  // ****************************************************************
  // latch or pin by direction
  always_comb begin
    rdata_d = 8'h00;
    if (bus_addr_in == port_pkg::port_a_data_offset) begin
      rdata_d = port_view(dir_a_q, latch_a_q, sync_a);
    end else if (bus_addr_in == port_pkg::port_b_data_offset) begin
      rdata_d = port_view(dir_b_q, latch_b_q, sync_b);
    end else if (bus_addr_in == port_pkg::port_c_data_offset) begin
      rdata_d = port_view(dir_c_eff, latch_c_q, sync_c);
    end else if (bus_addr_in == port_pkg::port_d_data_offset) begin
      rdata_d = sync_d;
    end else if (bus_addr_in == port_pkg::port_a_dir_offset) begin
      rdata_d = dir_a_q;
    end else if (bus_addr_in == port_pkg::port_b_dir_offset) begin
      rdata_d = dir_b_q;
    end else if (bus_addr_in == port_pkg::port_c_dir_offset) begin
      rdata_d = dir_c_q;
    end else if (bus_addr_in == port_pkg::nv_clock_ctrl_offset) begin
      // Each control bit returns at its own field position.
      rdata_d[port_pkg::clock_out_select_bit] = clock_out_select_q;
      rdata_d[port_pkg::nv_erase_select_bit] = nv_bits_q[2];
      rdata_d[port_pkg::nv_latch_select_bit] = nv_bits_q[1];
      rdata_d[port_pkg::nv_program_pulse_bit] = nv_bits_q[0];
    end else if (bus_addr_in == port_pkg::converter_ctrl_offset) begin
      rdata_d[port_pkg::converter_power_on_bit] = converter_power_on_q;
    end
  end

  // Read data and side outputs come from flops.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bus_rdata_out <= 8'h00;
      converter_power_on_out <= 1'b0;
      nv_ctrl_out <= 3'h0;
    end else begin
      bus_rdata_out <= bus_read_in ? rdata_d : 8'h00;
      converter_power_on_out <= converter_power_on_q;
      nv_ctrl_out <= nv_bits_q;
    end
  end

endmodule

/* File: tb/pin_board.sv */
`timescale 1ns/100ps
// ***
// Board model on one port.
// ***
module pin_board (
  // Device side.
  input wire logic [7:0] drive_in,
  input wire logic [7:0] oe_in,
  // Board side.
  input wire logic [7:0] board_in,
  output logic [7:0] level_out
);
  // drive when enabled
  // The board level shows wherever the device does not drive.
  assign level_out = (drive_in & oe_in) | (board_in & ~oe_in);
endmodule

/* File: tb/pio_chk.sv */
`timescale 1ns/100ps
// ***
// Port block checker.
// ***
module pio_chk (
  // Clock, reset and bus.
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] bus_addr_in,
  input wire logic bus_write_in,
  input wire logic bus_read_in,
  input wire logic [7:0] bus_wdata_in,
  input wire logic [7:0] bus_rdata_out,
  // Pins and control outputs.
  input wire logic [7:0] port_a_pins_out,
  input wire logic [7:0] port_a_pins_oe_out,
  input wire logic [7:0] port_c_pins_out,
  input wire logic [7:0] port_c_pins_oe_out,
  input wire logic [7:0] shared_input_pins_in,
  input wire logic converter_power_on_out,
  input wire logic [2:0] nv_ctrl_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // Decoded write strobes.
  wire wr_dir_a = bus_write_in && bus_addr_in == 8'h04;
  wire wr_dat_a = bus_write_in && bus_addr_in == 8'h00;
  wire wr_ctl = bus_write_in && bus_addr_in == 8'h07;
  wire wr_cnv = bus_write_in && bus_addr_in == 8'h09;
  logic sel_q;
  // Tracks the clock-out select as last written.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sel_q <= 1'b0;
    end else if (wr_ctl) begin
      sel_q <= bus_wdata_in[3];
    end
  end
  sequence s_settled(logic w);
    w ##1 !w [*2];
  endsequence
  property p_rst_clear;
    $rose(reset_n_in) |-> port_a_pins_oe_out == 8'h00 &&
      port_c_pins_oe_out == 8'h00 && nv_ctrl_out == 3'h0 &&
      !converter_power_on_out;
  endproperty
  property p_dir_drive;
    s_settled(wr_dir_a) |=> port_a_pins_oe_out == $past(bus_wdata_in, 3);
  endproperty
  property p_latch_out;
    s_settled(wr_dat_a) |=> (port_a_pins_out & port_a_pins_oe_out) ==
      ($past(bus_wdata_in, 3) & port_a_pins_oe_out);
  endproperty
  property p_rd_dir;
    bus_read_in && bus_addr_in == 8'h04 |=>
      bus_rdata_out == port_a_pins_oe_out;
  endproperty
  property p_idle_rd;
    !bus_read_in |=> bus_rdata_out == 8'h00;
  endproperty
  property p_nv;
    s_settled(wr_ctl) |=> nv_ctrl_out == $past(bus_wdata_in[2:0], 3);
  endproperty
  property p_cnv;
    s_settled(wr_cnv) |=> converter_power_on_out == $past(bus_wdata_in[5], 3);
  endproperty
  property p_in_port;
    $stable(shared_input_pins_in) [*4] ##0
      (bus_read_in && bus_addr_in == 8'h03) |=>
      bus_rdata_out == $past(shared_input_pins_in);
  endproperty
  property p_clk_out;
    sel_q [*4] |-> port_c_pins_oe_out[2] &&
      port_c_pins_out[2] != $past(port_c_pins_out[2]);
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("state not cleared by reset");
  a_dir_drive: assert property (p_dir_drive)
    else $error("enable differs from direction");
  a_latch_out: assert property (p_latch_out)
    else $error("driven value differs from latch");
  a_rd_dir: assert property (p_rd_dir)
    else $error("direction readback wrong");
  a_idle_rd: assert property (p_idle_rd)
    else $error("read data not zero when idle");
  a_nv: assert property (p_nv)
    else $error("control bits wrong");
  a_cnv: assert property (p_cnv)
    else $error("converter power wrong");
  a_in_port: assert property (p_in_port)
    else $error("input port read wrong");
  a_clk_out: assert property (p_clk_out)
    else $error("clock output not toggling");
endmodule
bind parallel_io_ports pio_chk chk (.*);

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
// ***
// Port block testbench.
// ***
module tb_top;
  logic clk = 1'b0;
  logic rst_n, wr_s, rd_s, t0, cnv;
  logic [7:0] addr, wdata, rdata, sh;
  logic [2:0] nv;
  logic [7:0] brd [3];
  wire logic [7:0] po [3];
  wire logic [7:0] poe [3];
  wire logic [7:0] lvl [3];
  int err_count = 0;
  int checks_done = 0;
  // Free-running core clock.
  always #2.5 clk = ~clk;
  parallel_io_ports uut (.core_clk_in(clk), .reset_n_in(rst_n),
    .bus_addr_in(addr), .bus_write_in(wr_s), .bus_read_in(rd_s),
    .bus_wdata_in(wdata), .bus_rdata_out(rdata),
    .port_a_pins_in(lvl[0]), .port_a_pins_out(po[0]),
    .port_a_pins_oe_out(poe[0]), .port_b_pins_in(lvl[1]),
    .port_b_pins_out(po[1]), .port_b_pins_oe_out(poe[1]),
    .port_c_pins_in(lvl[2]), .port_c_pins_out(po[2]),
    .port_c_pins_oe_out(poe[2]), .shared_input_pins_in(sh),
    .converter_power_on_out(cnv), .nv_ctrl_out(nv));
  for (genvar g = 0; g < 3; g++) begin : g_brd
    pin_board pb (.drive_in(po[g]), .oe_in(poe[g]), .board_in(brd[g]),
      .level_out(lvl[g]));
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic idle();
    repeat (4) @(posedge clk);
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    #20000;
    err_count++;
    summarize();
  end
  // Main sequence of register accesses.
  initial begin
    rst_n = 1'b0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    sh = 8'h96;
    brd = '{8'h5a, 8'ha5, 8'h3c};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    idle();
    for (int i = 0; i < 3; i++) begin
      rd(8'(i + 4), 8'h00);
      chk(poe[i], 8'h00);
    end
    rd(8'h07, 8'h00);
    rd(8'h09, 8'h00);
    rd(8'h03, 8'h96);
    // Each port: latch first, then half the pins as outputs.
    for (int i = 0; i < 3; i++) begin
      wr(8'(i), 8'hc3);
      idle();
      rd(8'(i), brd[i]);
      chk(poe[i], 8'h00);
      wr(8'(i + 4), 8'hf0);
      idle();
      chk(poe[i], 8'hf0);
      chk(lvl[i], {4'hc, brd[i][3:0]});
      rd(8'(i), {4'hc, brd[i][3:0]});
      rd(8'(i + 4), 8'hf0);
    end
    // Reset in mid-run keeps the latch.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    idle();
    chk(poe[0], 8'h00);
    wr(8'h04, 8'hff);
    idle();
    rd(8'h00, 8'hc3);
    chk(lvl[0], 8'hc3);
    wr(8'h06, 8'hf0);
    wr(8'h07, 8'hff);
    idle();
    chk({5'h00, nv}, 8'h07);
    rd(8'h07, 8'h0f);
    chk(poe[2], 8'hf4);
    rd(8'h06, 8'hf0);
    rd(8'h02, 8'hc8);
    @(posedge clk);
    #1 t0 = lvl[2][2];
    @(posedge clk);
    #1 chk({7'h00, lvl[2][2]}, {7'h00, ~t0});
    wr(8'h07, 8'h00);
    idle();
    chk(poe[2], 8'hf0);
    rd(8'h02, 8'hcc);
    @(posedge clk);
    sh <= 8'h69;
    idle();
    rd(8'h03, 8'h69);
    wr(8'h09, 8'h20);
    idle();
    chk({7'h00, cnv}, 8'h01);
    rd(8'h09, 8'h20);
    wr(8'h03, 8'h00);
    rd(8'h03, 8'h69);
    rd(8'h0a, 8'h00);
    summarize();
  end
endmodule
